// File: rtl/asc_defs.svh
// timing counts and widths for the async memory controller
`ifndef ASC_DEFS_SVH
`define ASC_DEFS_SVH
`define ASC_ADDR_W        18
`define ASC_DATA_W        16
`define ASC_CLK_PS        4000
`define ASC_POWER_US      100
`define ASC_POWER_CYC     ((`ASC_POWER_US * 1000000 + `ASC_CLK_PS - 1) / `ASC_CLK_PS)
`define ASC_RC_NS         10
`define ASC_RC_CYC        ((`ASC_RC_NS * 1000 + `ASC_CLK_PS - 1) / `ASC_CLK_PS)
`define ASC_WFLOAT_NS     5
`define ASC_WSETUP_NS     6
`define ASC_WP_NS         (`ASC_WFLOAT_NS + `ASC_WSETUP_NS)
`define ASC_WP_CYC        ((`ASC_WP_NS * 1000 + `ASC_CLK_PS - 1) / `ASC_CLK_PS)
`define ASC_TURN_NS       6
`define ASC_TURN_CYC      ((`ASC_TURN_NS * 1000 + `ASC_CLK_PS - 1) / `ASC_CLK_PS)
`define ASC_CNT_W         17
`endif

// File: rtl/asc_pkg.sv
// types for the async memory controller
package asc_pkg;
  typedef enum logic [2:0] {ST_POWER, ST_IDLE, ST_READ, ST_WRITE, ST_TURN} asc_state_t;
endpackage

// File: rtl/asc_timer.sv
// down counter that times each phase of a memory cycle
`timescale 1ns/100ps
`include "asc_defs.svh"
module asc_timer
(
  input  wire logic                  mclk_i,
  input  wire logic                  rst_b_i,
  input  wire logic                  load_i,
  input  wire logic [`ASC_CNT_W-1:0] value_i,
  output logic                       done_o
);
  logic [`ASC_CNT_W-1:0] cnt_q;
  assign done_o = (cnt_q == '0);
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      cnt_q <= '0;
    else if (load_i)
      cnt_q <= value_i;
    else if (!done_o)
      cnt_q <= cnt_q - 1'b1;
  end
endmodule

// File: rtl/asc_ctrl.sv
// host-side controller for a 256k x 16 asynchronous static memory
// Functional notes
// - start writes with select, write, lane low
// - time data against the closing control edge
// - write pulse at least float plus setup
// - write enable stays high through reads
// - address valid before select falls; the code changes address and select on the same edge
// - wait 100 us after reset before access
// - write data set up 6 ns before close
// - hold write data to close edge
`timescale 1ns/100ps
`include "asc_defs.svh"
module asc_ctrl
  import asc_pkg::*;
(
  input  wire logic                   mclk_i,
  input  wire logic                   rst_b_i,
  input  wire logic                   req_i,
  input  wire logic                   we_i,
  input  wire logic [`ASC_ADDR_W-1:0] addr_i,
  input  wire logic [`ASC_DATA_W-1:0] wdata_i,
  input  wire logic [1:0]             lane_i,
  output logic                        ready_o,
  output logic                        rvalid_o,
  output logic [`ASC_DATA_W-1:0]      rdata_o,
  output logic [`ASC_ADDR_W-1:0]      mem_addr_o,
  output logic                        chip_select_n_o,
  output logic                        output_enable_n_o,
  output logic                        write_enable_n_o,
  output logic                        low_lane_enable_n_o,
  output logic                        high_lane_enable_n_o,
  input  wire logic [`ASC_DATA_W-1:0] mem_data_i,
  output logic [`ASC_DATA_W-1:0]      mem_data_o,
  output logic                        mem_data_oe_o
);
  asc_state_t             state_q, state_d;
  logic                   ready_q, rvalid_q, cs_n_q, oe_n_q, we_n_q, doe_q;
  logic [1:0]             lane_n_q;
  logic [`ASC_ADDR_W-1:0] addr_q;
  logic [`ASC_DATA_W-1:0] wdata_q, rdata_q;
  logic                   tmr_load, tmr_done;
  logic [`ASC_CNT_W-1:0]  tmr_val;

  // counts rounded up so every minimum is met
  localparam logic [`ASC_CNT_W-1:0] POWER_C = `ASC_CNT_W'(`ASC_POWER_CYC - 1);
  localparam logic [`ASC_CNT_W-1:0] RC_C    = `ASC_CNT_W'(`ASC_RC_CYC);
  localparam logic [`ASC_CNT_W-1:0] WP_C    = `ASC_CNT_W'(`ASC_WP_CYC);
  localparam logic [`ASC_CNT_W-1:0] TURN_C  = `ASC_CNT_W'(`ASC_TURN_CYC);

  // both access states hold chip select low
  function automatic logic in_access(input asc_state_t s);
    in_access = (s == ST_READ) || (s == ST_WRITE);
  endfunction

  // power-up wait has its own counter so the shared timer stays free for memory cycles
  logic [`ASC_CNT_W-1:0] pwr_q;
  wire                   pwr_done  = (pwr_q == POWER_C);
  wire                   take      = (state_q == ST_IDLE) && req_i;
  wire                   cycle_end = tmr_done && in_access(state_q);

  // the load decision must not look at the load itself, or it forms a loop
  assign tmr_load = take || cycle_end;
  assign tmr_val  = take ? (we_i ? WP_C : RC_C) : TURN_C;

  asc_timer u_timer
  (
    .mclk_i  (mclk_i),
    .rst_b_i (rst_b_i),
    .load_i  (tmr_load),
    .value_i (tmr_val),
    .done_o  (tmr_done)
  );

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ST_POWER: if (pwr_done) state_d = ST_IDLE;
      ST_IDLE:  if (req_i) state_d = we_i ? ST_WRITE : ST_READ;
      ST_READ:  if (cycle_end) state_d = ST_TURN;
      ST_WRITE: if (cycle_end) state_d = ST_TURN;
      ST_TURN:  if (tmr_done) state_d = ST_IDLE;
      default:  state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      state_q <= ST_POWER;
    else
      state_q <= state_d;
  end

  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      pwr_q <= '0;
    else if (!pwr_done)
      pwr_q <= pwr_q + 1'b1;
  end

  // address and write data are latched on the edge where select falls and held to the closing edge
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      addr_q   <= '0;
      wdata_q  <= '0;
      cs_n_q   <= 1'b1;
      oe_n_q   <= 1'b1;
      we_n_q   <= 1'b1;
      lane_n_q <= 2'b11;
      doe_q    <= 1'b0;
    end
    else if (take && pwr_done)
    begin
      addr_q   <= addr_i;
      wdata_q  <= wdata_i;
      cs_n_q   <= 1'b0;
      we_n_q   <= !we_i;
      oe_n_q   <= we_i;
      lane_n_q <= ~lane_i;
      doe_q    <= we_i;
    end
    else if (cycle_end)
    begin
      // all controls rise together; data held through this edge, hold of zero met
      cs_n_q   <= 1'b1;
      we_n_q   <= 1'b1;
      oe_n_q   <= 1'b1;
      lane_n_q <= 2'b11;
    end
    else if (state_q == ST_TURN)
      doe_q    <= 1'b0;     // release bus one cycle after close, memory stays floated
  end

  // read data sampled at the end of the access window, whole word taken whatever the lanes
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      rdata_q  <= '0;
      rvalid_q <= 1'b0;
      ready_q  <= 1'b0;
    end
    else
    begin
      rvalid_q <= cycle_end && (state_q == ST_READ);
      if (cycle_end && state_q == ST_READ)
        rdata_q <= mem_data_i;
      ready_q  <= pwr_done && (state_d == ST_IDLE) && !take;
    end
  end

  assign ready_o              = ready_q;
  assign rvalid_o             = rvalid_q;
  assign rdata_o              = rdata_q;
  assign mem_addr_o           = addr_q;
  assign chip_select_n_o      = cs_n_q;
  assign output_enable_n_o    = oe_n_q;
  assign write_enable_n_o     = we_n_q;
  assign low_lane_enable_n_o  = lane_n_q[0];
  assign high_lane_enable_n_o = lane_n_q[1];
  assign mem_data_o           = wdata_q;
  assign mem_data_oe_o        = doe_q;


  // protocol checks on the pins this block drives
  a_read_we_high: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (!cs_n_q && !oe_n_q) |-> we_n_q) else $error("write enable low in read");
  a_first_access: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    !pwr_done |-> cs_n_q) else $error("access before power wait");
  sequence s_wr_open;
    $fell(we_n_q) && !cs_n_q;
  endsequence
  sequence s_wr_pulse;
    !we_n_q [*4];
  endsequence
  a_write_width: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    s_wr_open |-> s_wr_pulse) else $error("write pulse short");
  a_write_oe_off: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    !we_n_q |-> oe_n_q) else $error("output enable low in write");
  a_write_start: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    !we_n_q |-> (!cs_n_q && lane_n_q != 2'b11)) else $error("write without all controls");
  a_data_hold: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    $rose(we_n_q) |-> $stable(wdata_q) && doe_q) else $error("write data not held");
  a_data_setup: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (!we_n_q && !$fell(we_n_q)) |-> ($stable(wdata_q) && doe_q)) else $error("write data moved in pulse");
  a_data_release: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    $rose(cs_n_q) |-> ##1 !doe_q) else $error("data bus not released");
  a_addr_stable: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (!cs_n_q && !$fell(cs_n_q)) |-> $stable(addr_q)) else $error("address moved in cycle");
  a_lane_hold: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (!cs_n_q && !$fell(cs_n_q)) |-> ($stable(lane_n_q) && $stable(we_n_q))) else $error("controls moved in cycle");
  sequence s_rd_open;
    $fell(cs_n_q) && we_n_q;
  endsequence
  sequence s_rd_answer;
    !cs_n_q [*4] ##1 rvalid_q;
  endsequence
  a_read_time: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    s_rd_open |-> s_rd_answer) else $error("read not sampled after access");
  a_rvalid_pulse: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    rvalid_q |-> ##1 !rvalid_q) else $error("read valid longer than one cycle");
  a_ready_quiet: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    ready_q |-> (cs_n_q && pwr_done)) else $error("ready while memory busy");
  a_turn_gap: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    $rose(cs_n_q) |-> cs_n_q [*2]) else $error("no turnaround gap");
endmodule

// File: verification/asc_mem_model.sv
// behavioural model of the 256k x 16 asynchronous memory
`timescale 1ns/100ps
module asc_mem_model
(
  input  wire logic        cs_n_i,
  input  wire logic        oe_n_i,
  input  wire logic        we_n_i,
  input  wire logic        lo_n_i,
  input  wire logic        hi_n_i,
  input  wire logic [17:0] addr_i,
  input  wire logic [15:0] data_i,
  output logic      [15:0] data_o
);
  logic [15:0] mem [0:262143];
  logic [17:0] a_q;
  logic [15:0] d_q;
  logic        lo_q;
  logic        hi_q;
  wire         wr_on = !cs_n_i && !we_n_i && (!lo_n_i || !hi_n_i);
  wire         rd_on = !cs_n_i && !oe_n_i && we_n_i;
  wire  [15:0] word  = mem[addr_i];
  // lanes may rise with the closing edge, so keep what was seen while open
  always @(*)
  begin
    if (wr_on)
    begin
      a_q = addr_i;
      d_q = data_i;
      lo_q = !lo_n_i;
      hi_q = !hi_n_i;
    end
  end
  always @(negedge wr_on)
  begin
    if (lo_q) mem[a_q][7:0] = d_q[7:0];
    if (hi_q) mem[a_q][15:8] = d_q[15:8];
  end
  // floating lanes show the inverse, not a stale copy; slowest legal access
  assign #10 data_o = {(rd_on && !hi_n_i) ? word[15:8] : ~word[15:8],
                       (rd_on && !lo_n_i) ? word[7:0] : ~word[7:0]};
endmodule

// File: verification/asc_ctrl_test.sv
// self-checking bench for the async memory controller
`timescale 1ns/100ps
module asc_ctrl_test;
  logic        mclk_i = 0;
  logic        rst_b_i = 0;
  logic        req_i = 0;
  logic        we_i = 0;
  logic [17:0] addr_i = 18'h0_0000;
  logic [15:0] wdata_i = 16'h0000;
  logic [1:0]  lane_i = 2'h0;
  logic        ready_o, rvalid_o, cs_n, oe_n, we_n, lo_n, hi_n, d_oe, cs_q;
  logic [15:0] rdata_o, d_out, d_in, r;
  logic [17:0] m_addr, a_q;
  wire  [15:0] bus_w = d_oe ? d_out : ~d_out;
  int          n_mismatch = 0;
  int          checks = 0;
  int          cyc = 0;
  always #2 mclk_i = ~mclk_i;
  asc_ctrl i_dut (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .req_i(req_i), .we_i(we_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .lane_i(lane_i), .ready_o(ready_o), .rvalid_o(rvalid_o), .rdata_o(rdata_o),
    .mem_addr_o(m_addr), .chip_select_n_o(cs_n), .output_enable_n_o(oe_n), .write_enable_n_o(we_n),
    .low_lane_enable_n_o(lo_n), .high_lane_enable_n_o(hi_n), .mem_data_i(d_in), .mem_data_o(d_out),
    .mem_data_oe_o(d_oe));
  asc_mem_model i_mem (.cs_n_i(cs_n), .oe_n_i(oe_n), .we_n_i(we_n), .lo_n_i(lo_n), .hi_n_i(hi_n),
    .addr_i(m_addr), .data_i(bus_w), .data_o(d_in));
  task report_and_stop;
    if (n_mismatch == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic cmp(input logic [17:0] exp, input logic [17:0] got);
    checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %0t exp %h got %h", $time, exp, got);
    end
  endtask
  // one memory request; held to the rising edge after ready is seen at a falling edge, then reads wait for read valid and writes return
  task op(input logic w, input logic [17:0] a, input logic [15:0] d, input logic [1:0] l);
    int k;
    @(posedge mclk_i);
    req_i <= 1;
    we_i <= w;
    addr_i <= a;
    wdata_i <= d;
    lane_i <= l;
    k = 0;
    @(negedge mclk_i);
    while (ready_o !== 1'b1 && k < 50)
    begin
      @(negedge mclk_i);
      k++;
    end
    @(posedge mclk_i);
    req_i <= 0;
    addr_i <= ~a;
    wdata_i <= ~d;
    k = 0;
    r = 16'hxxxx;
    if (!w)
    begin
      while (rvalid_o !== 1'b1 && k < 10)
      begin
        @(negedge mclk_i);
        k++;
      end
      r = (rvalid_o === 1'b1) ? rdata_o : 16'hxxxx;
    end
  endtask
  task t_power;
    int n;
    n = 0;
    @(negedge mclk_i);
    while (ready_o !== 1'b1 && n < 26000)
    begin
      @(negedge mclk_i);
      n++;
    end
    cmp(1'b1, ready_o);
    cmp(1'b1, (n + 1) >= 25000);
  endtask
  task t_word;
    op(1, 18'h3_ffff, 16'ha5c3, 2'h3);
    op(0, 18'h3_ffff, 16'h0000, 2'h3);
    cmp(16'ha5c3, r);
  endtask
  // back-to-back partial writes must leave the other byte alone
  task t_lanes;
    op(1, 18'h0_0000, 16'h1234, 2'h3);
    op(1, 18'h0_0000, 16'h00ab, 2'h1);
    op(1, 18'h0_0000, 16'hcd00, 2'h2);
    op(0, 18'h0_0000, 16'h0000, 2'h3);
    cmp(16'hcdab, r);
    op(0, 18'h0_0000, 16'h0000, 2'h1);
    cmp(8'hab, r[7:0]);
  endtask
  always @(negedge mclk_i)
  begin
    if (rst_b_i && !cs_n && !oe_n) cmp(1'b1, we_n);
    if (rst_b_i && !cs_n && !oe_n) cmp(1'b0, d_oe);
    if (rst_b_i && !we_n) cmp(1'b0, cs_n | (lo_n & hi_n));
    if (rst_b_i && !cs_n && !cs_q) cmp(a_q, m_addr);
    cs_q <= cs_n;
    a_q <= m_addr;
  end
  always @(posedge mclk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      n_mismatch++;
      report_and_stop;
    end
  end
  initial
  begin
    repeat (16) @(posedge mclk_i);
    rst_b_i <= 1;
    t_power;
    t_word;
    t_lanes;
    report_and_stop;
  end
endmodule
